// [src/slave_state_pkg.sv]
// Purpose: shared constants for the slave state and watchdog block
// Assumes: 100 MHz pclk, APB data 32 bits
// Notes: state codes and own register offsets are fixed here only
package slave_state_pkg;
  // register byte offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam logic [11:0] DPM_OFS = 12'h008;
  localparam logic [11:0] MULT_OFS = 12'h400;
  localparam logic [11:0] LOC_CNT_OFS = 12'h410;
  localparam logic [11:0] FB_CNT_OFS = 12'h420;
  // control and status field positions
  localparam int CTRL_FB_EN_BIT = 4;
  localparam int CTRL_LOC_EN_BIT = 5;
  localparam int STAT_ERR_BIT = 4;
  localparam int STAT_FB_EXP_BIT = 5;
  localparam int STAT_LOC_EXP_BIT = 6;
  // state codes as seen by software
  localparam logic [3:0] CODE_INIT = 4'h1;
  localparam logic [3:0] CODE_PRECONF = 4'h2;
  localparam logic [3:0] CODE_BOOT = 4'h3;
  localparam logic [3:0] CODE_SAFE = 4'h4;
  localparam logic [3:0] CODE_FULL = 4'h8;
  // values after reset
  localparam logic [15:0] MULT_RST = 16'h09C2;
  localparam logic [15:0] FB_CNT_RST = 16'h03E8;
  localparam logic [15:0] LOC_CNT_RST = 16'h03E8;
  localparam logic FB_EN_RST = 1'b1;
  localparam logic LOC_EN_RST = 1'b1;
  localparam logic [7:0] SAFE_OUT = 8'h00;
  // timing: one base tick is one 25 MHz period
  localparam int CLK_PERIOD_NS = 10;
  localparam int BASE_TICK_NS = 40;
  localparam int BASE_CYC = BASE_TICK_NS / CLK_PERIOD_NS;
  localparam logic [1:0] BASE_LAST = 2'(BASE_CYC - 1);
  typedef enum logic [2:0] {st_init, st_preconf, st_safe, st_full, st_boot} slave_state_e;
endpackage

// [src/slave_state_watchdog.sv]
// Purpose: slave state sequencing, traffic gating and two comm watchdogs
// Assumes: all inputs synchronous to pclk; access strobes are one-cycle pulses
// Notes: register writes take effect at the APB access edge
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Operation
// RULE1: local watchdog expires when local accesses stop longer than enabled time.
// RULE2: watchdog time is count times (multiplier plus two) 40 ns base ticks.
// RULE3: reset values: multiplier 2498, fieldbus count 1000, i.e. 100 ms.
// RULE4: fieldbus watchdog with count zero is fully disabled.
// RULE5: expiry during safe-run or full-run forces outputs to safe value.
// RULE6: master commands every state change and sends needed commands.
// RULE7: after reset the slave is in startup, no mailbox or process data.
// RULE8: master sets up sync manager channels 0 and 1 for mailbox in startup.
// RULE9: startup to preconfig only when mailbox channels are correctly set.
// RULE10: preconfig allows mailbox traffic, rejects process data.
// RULE11: master configures process data channels, mapping units and parameters.
// RULE12: preconfig to safe-run only when process data and clock settings good.
// RULE13: inputs copied into dual port memory before safe-run is acknowledged.
// RULE14: safe-run allows all traffic, updates inputs, keeps outputs safe.
// RULE15: master delivers valid output data before asking for full-run.
// RULE16: full-run applies master output data to physical outputs.
// RULE17: firmware-update entered only from startup.
// RULE18: firmware-update permits only file-transfer mailbox traffic.
// RULE19: a normal startup sequence ends in full-run.
// RULE20: fieldbus watchdog restarts on each process data access; expiry keeps state.
// RULE21: one multiplier shared by both watchdogs, separate count each.
// RULE22: illegal or failed transition leaves state unchanged and unacknowledged.
module slave_state_watchdog
  import slave_state_pkg::*;
#(
  parameter logic [15:0] MULT_RESET = MULT_RST,
  parameter logic [15:0] FB_CNT_RESET = FB_CNT_RST,
  parameter logic [15:0] LOC_CNT_RESET = LOC_CNT_RST
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mbx_cfg_ok,
  input wire logic pd_cfg_ok,
  input wire logic dc_used,
  input wire logic dc_cfg_ok,
  input wire logic pd_access,
  input wire logic local_access,
  input wire logic out_wr,
  input wire logic [7:0] out_data,
  input wire logic [7:0] in_data,
  output logic [7:0] dpm_in,
  output logic [7:0] phys_out,
  output logic mbx_allow,
  output logic file_only,
  output logic pd_allow,
  output logic state_ack
);

  typedef struct packed {
    slave_state_e state;
    logic [31:0] prdata;
    logic [15:0] mult;
    logic [15:0] fb_cnt;
    logic [15:0] loc_cnt;
    logic fb_en;
    logic loc_en;
    logic req_err;
    logic ack;
    logic [1:0] base_cnt;
    logic [16:0] tick_cnt;
    logic wtick;
    logic [15:0] fb_tmr;
    logic fb_exp;
    logic [15:0] loc_tmr;
    logic loc_exp;
    logic [7:0] dpm_in;
    logic [7:0] out_latch;
    logic [7:0] phys_out;
  } regs_s;

  regs_s q;
  regs_s d;
  logic wr_acc;
  logic setup;
  logic mapped;
  logic req_v;
  logic go_ok;
  logic base_pulse;
  logic fb_hit;
  logic loc_hit;
  slave_state_e target;
  logic [3:0] code;
  logic [31:0] rd;

  ////////////////////////////////////////////////////////////////////////////////
  // traffic gating follows the state directly
  assign mbx_allow = (q.state != st_init); // RULE7 RULE10 RULE14 RULE16
  assign file_only = (q.state == st_boot); // RULE18
  assign pd_allow = (q.state == st_safe) || (q.state == st_full); // RULE10 RULE18
  assign pready = 1'b1;
  assign prdata = q.prdata;
  assign pslverr = psel && penable && !mapped;
  assign dpm_in = q.dpm_in;
  assign phys_out = q.phys_out;
  assign state_ack = q.ack;
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite && mapped;
  assign req_v = wr_acc && (paddr == CTRL_OFS);
  // process data strobes outside an allowed state are dropped, not counted
  assign fb_hit = pd_access && pd_allow; // RULE10
  assign loc_hit = local_access;
  assign base_pulse = (q.base_cnt == BASE_LAST);

  ////////////////////////////////////////////////////////////////////////////////
  // address decode and read mux
  always_comb begin
    mapped = 1'b1;
    rd = 32'h0000_0000;
    code = CODE_INIT;
    case (q.state)
      st_preconf: code = CODE_PRECONF;
      st_safe: code = CODE_SAFE;
      st_full: code = CODE_FULL;
      st_boot: code = CODE_BOOT;
      default: code = CODE_INIT;
    endcase
    if (paddr == CTRL_OFS) begin
      rd[CTRL_FB_EN_BIT] = q.fb_en;
      rd[CTRL_LOC_EN_BIT] = q.loc_en;
    end else if (paddr == STAT_OFS) begin
      rd[3:0] = code;
      rd[STAT_ERR_BIT] = q.req_err;
      rd[STAT_FB_EXP_BIT] = q.fb_exp;
      rd[STAT_LOC_EXP_BIT] = q.loc_exp;
    end else if (paddr == DPM_OFS) begin
      rd[7:0] = q.dpm_in;
    end else if (paddr == MULT_OFS) begin
      rd[15:0] = q.mult;
    end else if (paddr == LOC_CNT_OFS) begin
      rd[15:0] = q.loc_cnt;
    end else if (paddr == FB_CNT_OFS) begin
      rd[15:0] = q.fb_cnt;
    end else begin
      mapped = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // requested target and whether the move is allowed from here
  always_comb begin
    target = q.state;
    go_ok = 1'b0;
    case (pwdata[3:0])
      CODE_INIT: target = st_init;
      CODE_PRECONF: target = st_preconf;
      CODE_SAFE: target = st_safe;
      CODE_FULL: target = st_full;
      CODE_BOOT: target = st_boot;
      default: target = q.state;
    endcase
    // an unknown code leaves target at the current state but is still refused
    if (pwdata[3:0] == CODE_INIT || target == q.state) begin
      go_ok = (pwdata[3:0] == CODE_INIT) || (pwdata[3:0] == code);
    end else begin
      case (q.state)
        st_init: begin
          if (target == st_preconf) begin
            go_ok = mbx_cfg_ok; // RULE9
          end else begin
            go_ok = (target == st_boot); // RULE17
          end
        end
        st_preconf: begin
          if (target == st_safe) begin
            go_ok = pd_cfg_ok && (!dc_used || dc_cfg_ok); // RULE12
          end
        end
        st_safe: go_ok = (target == st_preconf) || (target == st_full); // RULE19
        st_full: go_ok = (target == st_preconf) || (target == st_safe);
        default: go_ok = 1'b0; // RULE17
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state of everything
  always_comb begin
    d = q;
    d.ack = 1'b0;
    d.wtick = 1'b0;
    if (setup) begin
      d.prdata = rd;
    end
    // register writes
    if (wr_acc && paddr == CTRL_OFS) begin
      d.fb_en = pwdata[CTRL_FB_EN_BIT];
      d.loc_en = pwdata[CTRL_LOC_EN_BIT];
    end
    if (wr_acc && paddr == STAT_OFS && pwdata[STAT_ERR_BIT]) begin
      d.req_err = 1'b0;
    end
    if (wr_acc && paddr == MULT_OFS) begin
      d.mult = pwdata[15:0]; // RULE21
    end
    if (wr_acc && paddr == LOC_CNT_OFS) begin
      d.loc_cnt = pwdata[15:0];
    end
    if (wr_acc && paddr == FB_CNT_OFS) begin
      d.fb_cnt = pwdata[15:0];
    end
    // state change; the error flag is set after the clear so the set wins
    if (req_v) begin
      if (go_ok) begin
        d.state = target;
        d.ack = 1'b1;
      end else begin
        d.req_err = 1'b1; // RULE22
      end
    end
    // input image: snapshot on safe-run entry, then every cycle while running
    if ((req_v && go_ok && target == st_safe) || pd_allow) begin
      d.dpm_in = in_data; // RULE13 RULE14
    end
    if (out_wr && pd_allow) begin
      d.out_latch = out_data;
    end
    // outputs follow the master only in full-run with no watchdog tripped
    if (q.state == st_full && !q.fb_exp && !q.loc_exp) begin
      d.phys_out = q.out_latch; // RULE16
    end else begin
      d.phys_out = SAFE_OUT; // RULE5 RULE14
    end
    // shared tick: multiplier plus two base ticks per watchdog tick
    d.base_cnt = base_pulse ? 2'b00 : q.base_cnt + 2'b01;
    if (base_pulse) begin
      if (q.tick_cnt >= {1'b0, q.mult} + 17'd1) begin
        d.tick_cnt = 17'd0;
        d.wtick = 1'b1; // RULE2 RULE21
      end else begin
        d.tick_cnt = q.tick_cnt + 17'd1;
      end
    end
    // fieldbus watchdog; an expiry never touches the slave state
    if (!q.fb_en || q.fb_cnt == 16'h0000) begin
      d.fb_tmr = 16'h0000;
      d.fb_exp = 1'b0; // RULE4
    end else if (fb_hit) begin
      d.fb_tmr = 16'h0000;
      d.fb_exp = 1'b0; // RULE20
    end else if (q.wtick && !q.fb_exp) begin
      if (q.fb_tmr + 16'd1 >= q.fb_cnt) begin
        d.fb_exp = 1'b1; // RULE2
      end else begin
        d.fb_tmr = q.fb_tmr + 16'd1;
      end
    end
    // local interface watchdog, count zero also disables it
    if (!q.loc_en || q.loc_cnt == 16'h0000) begin
      d.loc_tmr = 16'h0000;
      d.loc_exp = 1'b0;
    end else if (loc_hit) begin
      d.loc_tmr = 16'h0000;
      d.loc_exp = 1'b0;
    end else if (q.wtick && !q.loc_exp) begin
      if (q.loc_tmr + 16'd1 >= q.loc_cnt) begin
        d.loc_exp = 1'b1; // RULE1
      end else begin
        d.loc_tmr = q.loc_tmr + 16'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.state <= st_init; // RULE7
      q.mult <= MULT_RESET; // RULE3
      q.fb_cnt <= FB_CNT_RESET; // RULE3
      q.loc_cnt <= LOC_CNT_RESET;
      q.fb_en <= FB_EN_RST;
      q.loc_en <= LOC_EN_RST;
      q.phys_out <= SAFE_OUT;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  startup_gate_a: assert property (q.state == st_init |-> !mbx_allow && !pd_allow) // RULE7
    else $error("traffic allowed in startup");
  preconf_gate_a: assert property (q.state == st_preconf |-> mbx_allow && !pd_allow) // RULE10
    else $error("process data allowed in preconfig");
  update_gate_a: assert property (q.state == st_boot |-> file_only && !pd_allow) // RULE18
    else $error("update state gating wrong");
  mbx_check_a: assert property ($changed(q.state) && q.state == st_preconf // RULE9
    && $past(q.state) == st_init |-> $past(mbx_cfg_ok))
    else $error("preconfig entered with bad mailbox");
  pd_check_a: assert property ($changed(q.state) && q.state == st_safe // RULE12
    && $past(q.state) == st_preconf |-> $past(pd_cfg_ok))
    else $error("safe-run entered with bad process data setup");
  input_copy_a: assert property ($rose(q.state == st_safe) |-> q.dpm_in == $past(in_data)) // RULE13
    else $error("inputs not copied on safe-run entry");
  boot_entry_a: assert property ($rose(q.state == st_boot) |-> $past(q.state) == st_init) // RULE17
    else $error("update state entered from wrong state");
  safe_out_a: assert property (!(q.state == st_full && !q.fb_exp && !q.loc_exp) // RULE5
    |=> q.phys_out == SAFE_OUT)
    else $error("outputs not safe");
  out_apply_a: assert property (q.state == st_full && !q.fb_exp && !q.loc_exp // RULE16
    |=> q.phys_out == $past(q.out_latch))
    else $error("full-run outputs not applied");
  bad_req_a: assert property (req_v && !go_ok |=> $stable(q.state) && q.req_err && !q.ack) // RULE22
    else $error("refused request changed state");
  wd_off_a: assert property (q.fb_cnt == 16'h0000 |=> !q.fb_exp) // RULE4
    else $error("zero count watchdog expired");
  // a state request may land on the same edge as an access, so state is held apart
  fb_restart_a: assert property (fb_hit && q.fb_en && q.fb_cnt != 16'h0000 // RULE20
    |=> !q.fb_exp && q.fb_tmr == 16'h0000)
    else $error("fieldbus watchdog not restarted");
  state_hold_a: assert property (!req_v |=> $stable(q.state)) // RULE20
    else $error("state changed without a request");
  tick_rate_a: assert property ($rose(q.wtick) |=> !q.wtick [*3]) // RULE2
    else $error("watchdog tick too fast");
endmodule

// [bench/bus_master_model.sv]
// Purpose: fieldbus master stand-in giving config flags and process data
// Assumes: pclk domain, pulses last one cycle
// Notes: out_data toggles between OUT_VAL and its inverse between writes
`timescale 1ns/1ps
module bus_master_model #(
  parameter logic [7:0] OUT_VAL = 8'h5A
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic cfg_good,
  input wire logic pd_allow,
  output logic mbx_cfg_ok,
  output logic pd_cfg_ok,
  output logic pd_access,
  output logic out_wr,
  output logic [7:0] out_data
);
  logic [1:0] cnt_q;
  logic wr_d;
  // channel setup is done by the master before each request
  assign mbx_cfg_ok = cfg_good;
  assign pd_cfg_ok = cfg_good;
  assign wr_d = go && pd_allow && (cnt_q == 2'h2);
  // traffic only while process data is open; valid data before full-run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 2'h0;
      pd_access <= 1'b0;
      out_wr <= 1'b0;
      out_data <= ~OUT_VAL;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      pd_access <= go && pd_allow && (cnt_q == 2'h0);
      out_wr <= wr_d;
      out_data <= wr_d ? OUT_VAL : ~out_data;
    end
  end
endmodule

// [bench/tb_slave_state_watchdog.sv]
// Purpose: self-checking bench for state control and watchdogs
// Assumes: apb slave, master model on the fieldbus side
// Notes: hand-written reset and refusal cases, then state table rows, then more hand-written cases
`timescale 1ns/1ps
module tb_slave_state_watchdog;
  import slave_state_pkg::*;
  localparam logic [7:0] OUT_VAL = 8'h5A;
  // request code, expected state, ack, mbx pd file gates
  localparam logic [11:0] ROWS [15] = '{12'h118, 12'h33D, 12'h235, 12'h118,
    12'h22C, 12'h324, 12'h824, 12'h44E, 12'h88E, 12'h22C, 12'h44E, 12'h88E,
    12'h44E, 12'h88E, 12'h586};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic go = 1'b1;
  logic cfg_good = 1'b1;
  logic dc_used = 1'b0;
  logic dc_cfg_ok = 1'b0;
  logic local_access = 1'b0;
  logic [7:0] in_data = 8'h00;
  logic [31:0] prdata, rdat;
  logic [7:0] out_data, dpm_in, phys_out;
  logic pready, pslverr, mbx_cfg_ok, pd_cfg_ok, pd_access, out_wr, rerr;
  logic mbx_allow, file_only, pd_allow, state_ack;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  slave_state_watchdog uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .mbx_cfg_ok, .pd_cfg_ok, .dc_used,
    .dc_cfg_ok, .pd_access, .local_access, .out_wr, .out_data, .in_data,
    .dpm_in, .phys_out, .mbx_allow, .file_only, .pd_allow, .state_ack);
  bus_master_model #(.OUT_VAL(OUT_VAL)) master (.pclk, .presetn, .go, .cfg_good,
    .pd_allow, .mbx_cfg_ok, .pd_cfg_ok, .pd_access, .out_wr, .out_data);
  always #5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // pready seen high ends this wait, or else the bench timeout
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_out(input int n, input logic [7:0] ex);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
    chk("phys_out", 32'(ex), 32'(phys_out));
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("gates", 32'h0, 32'({mbx_allow, pd_allow, file_only}));
    chk("pready", 32'h1, 32'(pready));
    apb(1'b0, STAT_OFS, 32'h0);
    chk("stat", 32'h01, rdat);
    apb(1'b0, MULT_OFS, 32'h0);
    chk("mult", 32'h09C2, rdat);
    apb(1'b0, FB_CNT_OFS, 32'h0);
    chk("fb count", 32'h03E8, rdat);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl", 32'h30, rdat);
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped", 32'h1, {rdat[31:1], rerr});
    $display("test reset done");
    cfg_good <= 1'b0;
    apb(1'b1, CTRL_OFS, 32'h32);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("mbx refused", 32'h11, rdat);
    apb(1'b1, STAT_OFS, 32'h10);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("err clear", 32'h01, rdat);
    cfg_good <= 1'b1;
    dc_used <= 1'b1;
    apb(1'b1, CTRL_OFS, 32'h32);
    apb(1'b1, CTRL_OFS, 32'h34);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("dc refused", 32'h12, rdat);
    dc_cfg_ok <= 1'b1;
    apb(1'b1, CTRL_OFS, 32'h34);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("dc ok", 32'h14, rdat);
    apb(1'b1, CTRL_OFS, 32'h31);
    $display("test refusal done");
    foreach (ROWS[i]) begin
      apb(1'b1, CTRL_OFS, {26'h0, 2'b11, ROWS[i][11:8]});
      @(negedge pclk);
      chk("ack", 32'(ROWS[i][3]), 32'(state_ack));
      chk("gates", 32'(ROWS[i][2:0]), 32'({mbx_allow, pd_allow, file_only}));
      apb(1'b0, STAT_OFS, 32'h0);
      chk("state", 32'(ROWS[i][7:4]), 32'(rdat[3:0]));
    end
    $display("test rows done");
    apb(1'b1, CTRL_OFS, 32'h32);
    in_data <= 8'h3C;
    apb(1'b1, CTRL_OFS, 32'h34);
    // at the falling edge after the accepting edge the snapshot must already stand
    @(negedge pclk);
    chk("dpm snapshot", 32'h3C, 32'(dpm_in));
    apb(1'b0, DPM_OFS, 32'h0);
    chk("dpm entry", 32'h3C, rdat);
    in_data <= 8'hC3;
    wait_out(8, SAFE_OUT);
    chk("dpm cyclic", 32'hC3, 32'(dpm_in));
    apb(1'b1, CTRL_OFS, 32'h38);
    wait_out(8, OUT_VAL);
    $display("test io done");
    apb(1'b1, STAT_OFS, 32'h10);
    apb(1'b1, MULT_OFS, 32'h0);
    apb(1'b1, FB_CNT_OFS, 32'h3);
    wait_out(60, OUT_VAL);
    @(posedge pclk);
    go <= 1'b0;
    repeat (40) @(posedge pclk);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("fb expired", 32'h28, rdat);
    wait_out(0, SAFE_OUT);
    @(posedge pclk);
    go <= 1'b1;
    wait_out(12, OUT_VAL);
    apb(1'b1, FB_CNT_OFS, 32'h0);
    go <= 1'b0;
    wait_out(60, OUT_VAL);
    apb(1'b1, LOC_CNT_OFS, 32'h3);
    local_access <= 1'b1;
    @(posedge pclk);
    local_access <= 1'b0;
    wait_out(11, OUT_VAL);
    repeat (20) @(posedge pclk);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("local expired", 32'h48, rdat);
    wait_out(0, SAFE_OUT);
    $display("test watchdog done");
    // reset in mid-run from full-run: gates close, registers reload
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk("reset gates", 32'h0, 32'({mbx_allow, pd_allow, file_only}));
    chk("reset out", 32'(SAFE_OUT), 32'(phys_out));
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, STAT_OFS, 32'h0);
    chk("reset stat", 32'h01, rdat);
    apb(1'b0, LOC_CNT_OFS, 32'h0);
    chk("loc count", 32'h03E8, rdat);
    $display("test mid reset done");
    test_done();
  end
endmodule
